// [inc/lgo_pkg.sv]
// Purpose: Shared constants and carrier types for the logic output block.
// Assumes: 100 MHz core clock, twelve rails, eight inputs, 32-bit APB.
// Notes:   Offsets are byte addresses; each register is one aligned word.
package lgo_pkg;

	// ------------------------------------------------------------
	// Sizes and rail-status type codes
	// ------------------------------------------------------------
	localparam int LGO_RAILS   = 12;
	localparam int LGO_NGPI    = 8;
	localparam int LGO_NGPO    = 8;
	// Live codes 0..16: power good, margin enable, margin low/not high,
	// Vout OV fault/warn, UV warn/fault, turn-on fault, turn-off warning,
	// Iout OC fault/warn, UC fault, temp OT fault/warn, seq on/off
	// timeout, watchdog timeout. Codes 17..30 latch live codes 3..16,
	// code 31 latches either sequencing timeout.
	localparam int LGO_N_LIVE  = 17;
	localparam int LGO_N_LATCH = 15;
	localparam int LGO_N_TYPES = 32;
	localparam int LGO_LATCH_SRC0 = 3;
	localparam int LGO_SEQ_ON  = 14;
	localparam int LGO_SEQ_OFF = 15;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] LGO_CTRL_OFF   = 12'h000;
	localparam logic [11:0] LGO_STAT_OFF   = 12'h004;
	localparam logic [11:0] LGO_LATCH_OFF  = 12'h008;
	localparam logic [11:0] LGO_OUT_BASE   = 12'h100;
	localparam int          LGO_OUT_SHIFT  = 5;
	localparam logic [2:0]  LGO_W_CFG      = 3'h0;
	localparam logic [2:0]  LGO_W_T0A      = 3'h1;
	localparam logic [2:0]  LGO_W_T0B      = 3'h2;
	localparam logic [2:0]  LGO_W_T1A      = 3'h3;
	localparam logic [2:0]  LGO_W_T1B      = 3'h4;

	// Field positions.
	localparam int LGO_CFG_SM   = 0;
	localparam int LGO_CFG_DA   = 1;
	localparam int LGO_CFG_DD   = 2;
	localparam int LGO_CFG_IGN  = 3;
	localparam int LGO_CFG_CNT  = 8;
	localparam int LGO_TA_TYPE  = 16;
	localparam int LGO_TB_GPO   = 8;
	localparam int LGO_CTRL_CLR = 0;
	localparam int LGO_CTRL_PEN = 4;
	localparam int LGO_CTRL_PSEL = 8;
	localparam int LGO_STAT_RES = 16;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int LGO_CLK_HZ      = 100_000_000;
	localparam int LGO_DLY_DEF_MS  = 3;
	localparam int LGO_DLY_DEF_CYC = LGO_DLY_DEF_MS * (LGO_CLK_HZ / 1000);

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [23:0] dly_cnt;
		logic        ignore;
		logic        dly_deassert;
		logic        dly_assert;
		logic        sm_en;
	} lgo_cfg_t;

	typedef struct packed {
		logic [4:0]            type_sel;
		logic [LGO_RAILS-1:0]  rail_mask;
		logic [LGO_NGPO-1:0]   gpo_mask;
		logic [LGO_NGPI-1:0]   gpi_mask;
	} lgo_term_t;

	typedef enum logic [1:0] {
		LGO_IDLE = 2'b00,
		LGO_WAIT = 2'b01,
		LGO_HOLD = 2'b10
	} lgo_dly_st_t;

	localparam lgo_cfg_t LGO_CFG_RST = '{
		dly_cnt: 24'(LGO_DLY_DEF_CYC), default: 1'b0};

endpackage

// [core/lgo_latch.sv]
// Purpose: Sticky rail-status flags for the latched status types.
// Assumes: Set and clear come from logic on core_clk.
// Notes:   A set in the cycle of a clear still leaves the flag set.
`timescale 1ns/1ps
module lgo_latch import lgo_pkg::*; #(
	parameter int RAILS = LGO_RAILS
) (
	input  wire logic                                  core_clk,
	input  wire logic                                  rst_n,
	input  wire logic [LGO_N_LATCH-1:0][RAILS-1:0]     set,
	input  wire logic                                  clr,
	output logic      [LGO_N_LATCH-1:0][RAILS-1:0]     flags
);

	typedef struct packed {
		logic [LGO_N_LATCH-1:0][RAILS-1:0] flag;
	} lgo_latch_st_t;

	lgo_latch_st_t s_q;
	lgo_latch_st_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.flag = set | (s_q.flag & ~{LGO_N_LATCH*RAILS{clr}});
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags = s_q.flag;

endmodule // lgo_latch

// [core/lgo_delay.sv]
// Purpose: Assertion and deassertion delay for one logic-driven output.
// Assumes: Input is a registered logic result on core_clk.
// Notes:   In ignore mode each output level is held for the full delay.
`timescale 1ns/1ps
module lgo_delay import lgo_pkg::*; (
	input  wire logic     core_clk,
	input  wire logic     rst_n,
	input  wire lgo_cfg_t cfg,
	input  wire logic     logic_in,
	output logic          pin_out
);

	typedef struct packed {
		lgo_dly_st_t st;
		logic [23:0] cnt;
		logic        target;
		logic        out;
	} lgo_dly_state_t;

	lgo_dly_state_t s_q;
	lgo_dly_state_t s_d;
	logic           need;
	logic           hold_on;

	always_comb begin
		s_d = s_q;
		need = logic_in ? cfg.dly_assert : cfg.dly_deassert;
		hold_on = cfg.ignore && (cfg.dly_cnt != 24'h0);
		unique case (s_q.st)
			LGO_IDLE: begin
				if (logic_in != s_q.out) begin
					if (need && (cfg.dly_cnt != 24'h0)) begin
						s_d.st = LGO_WAIT;
						s_d.cnt = cfg.dly_cnt;
						s_d.target = logic_in;
					end else begin
						s_d.out = logic_in;
						if (hold_on) begin
							s_d.st = LGO_HOLD;
							s_d.cnt = cfg.dly_cnt;
						end
					end
				end
			end
			LGO_WAIT: begin
				if (!cfg.ignore && (logic_in != s_q.target)) begin
					s_d.st = LGO_IDLE;
				end else if (s_q.cnt == 24'h1) begin
					s_d.out = s_q.target;
					s_d.st = hold_on ? LGO_HOLD : LGO_IDLE;
					s_d.cnt = cfg.dly_cnt;
				end else begin
					s_d.cnt = s_q.cnt - 24'h1;
				end
			end
			LGO_HOLD: begin
				if (s_q.cnt <= 24'h1) begin
					s_d.st = LGO_IDLE;
				end else begin
					s_d.cnt = s_q.cnt - 24'h1;
				end
			end
			default: begin
				s_d.st = LGO_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out = s_q.out;

endmodule // lgo_delay

// [core/lgo_logic_out.sv]
// Purpose: Boolean logic-driven outputs with delays, set up over APB.
// Assumes: Rail status and output states are synchronous to core_clk;
//          general-purpose input pins are asynchronous.
// Notes:   Output polarity and drive mode live outside this block.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// What this block does
// - Each output is the OR of up to two AND terms.
// - Terms take the first eight outputs, input pins and rail flags.
// - Each term picks one rail-status type and any subset of rails.
// - Latched flags stay set until command or input pin clears them.
// - Types cover good, margin, voltage, timing, current, temp, watchdog.
// - Delay may apply on assertion, deassertion, both or neither.
// - Normal mode: a change that reverts within the delay is filtered.
// - A change outlasting the delay reaches the output after it.
// - Ignore mode: a triggering change always passes after the delay.
// - Ignore mode: every output pulse lasts at least the delay.
// - State-machine mode evaluates only one AND term at a time.
// - While the result is true only term 0 is evaluated.
// - While the result is false only term 1 is evaluated.
module lgo_logic_out import lgo_pkg::*; #(
	parameter int NUM_OUT = 12
) (
	input  wire logic                                 core_clk,
	input  wire logic                                 resetn,
	input  wire logic [11:0]                          paddr,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [31:0]                          pwdata,
	output logic      [31:0]                          prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire logic [LGO_NGPI-1:0]                  gpi_pin,
	input  wire logic [LGO_N_LIVE-1:0][LGO_RAILS-1:0] rail_status,
	input  wire logic [LGO_NGPO-1:0]                  gpo_state,
	output logic      [NUM_OUT-1:0]                   logic_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LGO_NGPI-1:0]              gpi_s1;
		logic [LGO_NGPI-1:0]              gpi_s2;
		logic [NUM_OUT-1:0]               result;
		lgo_cfg_t [NUM_OUT-1:0]           cfg;
		lgo_term_t [NUM_OUT-1:0][1:0]     term;
		logic                             clr_pin_en;
		logic [2:0]                       clr_pin_sel;
		logic                             clr_pulse;
		logic [31:0]                      prdata;
		logic                             slverr;
	} lgo_state_t;

	localparam lgo_state_t ST_RST = '{
		cfg: {NUM_OUT{LGO_CFG_RST}}, default: '0};

	lgo_state_t s_q;
	lgo_state_t s_d;

	logic                                    rst_s1_q;
	logic                                    rst_n;
	logic [LGO_N_LATCH-1:0][LGO_RAILS-1:0]   latch_set;
	logic [LGO_N_LATCH-1:0][LGO_RAILS-1:0]   latched;
	logic [LGO_N_TYPES-1:0][LGO_RAILS-1:0]   stat_all;
	logic                                    clr;
	logic [NUM_OUT-1:0]                      t0;
	logic [NUM_OUT-1:0]                      t1;

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	// Release is synchronised so every flop leaves reset on one edge.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Rail status, live and latched
	// ------------------------------------------------------------
	always_comb begin
		for (int k = 0; k < LGO_N_LATCH - 1; k++) begin
			latch_set[k] = rail_status[LGO_LATCH_SRC0 + k];
		end
		latch_set[LGO_N_LATCH-1] = rail_status[LGO_SEQ_ON] |
			rail_status[LGO_SEQ_OFF];
	end

	// The clear pin is a level: while it is asserted, flags only follow their set inputs.
	assign clr = s_q.clr_pulse |
		(s_q.clr_pin_en & s_q.gpi_s2[s_q.clr_pin_sel]);

	lgo_latch #(
		.RAILS (LGO_RAILS)
	) u_latch (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.set      (latch_set),
		.clr      (clr),
		.flags    (latched)
	);

	assign stat_all = {latched, rail_status};

	// ------------------------------------------------------------
	// AND terms
	// ------------------------------------------------------------
	// An empty term is false, so an unused path never forces the OR.
	function automatic logic term_eval(
		input lgo_term_t                              t,
		input logic [LGO_N_TYPES-1:0][LGO_RAILS-1:0]  st,
		input logic [LGO_NGPI-1:0]                    gpi,
		input logic [LGO_NGPO-1:0]                    gpo
	);
		logic [LGO_RAILS-1:0] rails;
		logic                 used;
		logic                 all;
		rails = st[t.type_sel];
		used = |{t.rail_mask, t.gpo_mask, t.gpi_mask};
		all = (&(rails | ~t.rail_mask)) & (&(gpi | ~t.gpi_mask)) &
			(&(gpo | ~t.gpo_mask));
		return used & all;
	endfunction

	always_comb begin
		for (int n = 0; n < NUM_OUT; n++) begin
			t0[n] = term_eval(s_q.term[n][0], stat_all, s_q.gpi_s2,
				gpo_state);
			t1[n] = term_eval(s_q.term[n][1], stat_all, s_q.gpi_s2,
				gpo_state);
		end
	end

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [11:0] rel;
	logic [6:0]  oidx;
	logic [2:0]  word;
	logic        in_out;
	logic        hit;
	logic        acc;

	always_comb begin
		rel = paddr - LGO_OUT_BASE;
		oidx = rel[11:LGO_OUT_SHIFT];
		word = rel[4:2];
		in_out = (paddr >= LGO_OUT_BASE) && (32'(oidx) < NUM_OUT) &&
			(word <= LGO_W_T1B);
		hit = (paddr[1:0] == 2'b00) && (in_out ||
			paddr == LGO_CTRL_OFF || paddr == LGO_STAT_OFF ||
			paddr == LGO_LATCH_OFF);
		acc = psel & penable;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.gpi_s1 = gpi_pin;
		s_d.gpi_s2 = s_q.gpi_s1;
		s_d.clr_pulse = 1'b0;
		for (int n = 0; n < NUM_OUT; n++) begin
			if (s_q.cfg[n].sm_en) begin
				s_d.result[n] = s_q.result[n] ? t0[n] : t1[n];
			end else begin
				s_d.result[n] = t0[n] | t1[n];
			end
		end
		// Read data and error are captured in the setup cycle.
		if (psel && !penable) begin
			s_d.slverr = ~hit;
			s_d.prdata = 32'h0;
			if (in_out) begin
				unique case (word)
					LGO_W_CFG: begin
						s_d.prdata[LGO_CFG_SM] = s_q.cfg[oidx].sm_en;
						s_d.prdata[LGO_CFG_DA] = s_q.cfg[oidx].dly_assert;
						s_d.prdata[LGO_CFG_DD] = s_q.cfg[oidx].dly_deassert;
						s_d.prdata[LGO_CFG_IGN] = s_q.cfg[oidx].ignore;
						s_d.prdata[LGO_CFG_CNT +: 24] = s_q.cfg[oidx].dly_cnt;
					end
					LGO_W_T0A: s_d.prdata = {11'h0, s_q.term[oidx][0].type_sel,
						4'h0, s_q.term[oidx][0].rail_mask};
					LGO_W_T0B: s_d.prdata = {16'h0,
						s_q.term[oidx][0].gpo_mask, s_q.term[oidx][0].gpi_mask};
					LGO_W_T1A: s_d.prdata = {11'h0, s_q.term[oidx][1].type_sel,
						4'h0, s_q.term[oidx][1].rail_mask};
					LGO_W_T1B: s_d.prdata = {16'h0,
						s_q.term[oidx][1].gpo_mask, s_q.term[oidx][1].gpi_mask};
					default:   s_d.prdata = 32'h0;
				endcase
			end else if (paddr == LGO_CTRL_OFF) begin
				s_d.prdata[LGO_CTRL_PEN] = s_q.clr_pin_en;
				s_d.prdata[LGO_CTRL_PSEL +: 3] = s_q.clr_pin_sel;
			end else if (paddr == LGO_STAT_OFF) begin
				s_d.prdata[NUM_OUT-1:0] = logic_out;
				s_d.prdata[LGO_STAT_RES +: NUM_OUT] = s_q.result;
			end else if (paddr == LGO_LATCH_OFF) begin
				for (int k = 0; k < LGO_N_LATCH; k++) begin
					s_d.prdata[k] = |latched[k];
				end
			end
		end
		// Writes take effect at the access edge; read-only words ignore them.
		if (acc && pwrite && hit) begin
			if (in_out) begin
				unique case (word)
					LGO_W_CFG: begin
						s_d.cfg[oidx].sm_en = pwdata[LGO_CFG_SM];
						s_d.cfg[oidx].dly_assert = pwdata[LGO_CFG_DA];
						s_d.cfg[oidx].dly_deassert = pwdata[LGO_CFG_DD];
						s_d.cfg[oidx].ignore = pwdata[LGO_CFG_IGN];
						s_d.cfg[oidx].dly_cnt = pwdata[LGO_CFG_CNT +: 24];
					end
					LGO_W_T0A, LGO_W_T1A: begin
						s_d.term[oidx][word[1]].rail_mask = pwdata[LGO_RAILS-1:0];
						s_d.term[oidx][word[1]].type_sel =
							pwdata[LGO_TA_TYPE +: 5];
					end
					LGO_W_T0B, LGO_W_T1B: begin
						s_d.term[oidx][word[2]].gpi_mask = pwdata[LGO_NGPI-1:0];
						s_d.term[oidx][word[2]].gpo_mask =
							pwdata[LGO_TB_GPO +: LGO_NGPO];
					end
					default: begin
					end
				endcase
			end else if (paddr == LGO_CTRL_OFF) begin
				s_d.clr_pulse = pwdata[LGO_CTRL_CLR];
				s_d.clr_pin_en = pwdata[LGO_CTRL_PEN];
				s_d.clr_pin_sel = pwdata[LGO_CTRL_PSEL +: 3];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= ST_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Delays and outputs
	// ------------------------------------------------------------
	for (genvar n = 0; n < NUM_OUT; n++) begin : g_out
		lgo_delay u_delay (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.cfg      (s_q.cfg[n]),
			.logic_in (s_q.result[n]),
			.pin_out  (logic_out[n])
		);
	end

	assign prdata  = s_q.prdata;
	assign pslverr = s_q.slverr & acc;
	assign pready  = acc;

endmodule // lgo_logic_out

// [verif/lgo_logic_out_checker.sv]
// Purpose: Port-level checks for the logic output block.
// Assumes: One clock domain; resetn low clears all state.
// Notes:   Output 0 hold settings are shadowed from APB writes.
`timescale 1ns/1ps
module lgo_logic_out_checker import lgo_pkg::*; #(
	parameter int NUM_OUT = 12
) (
	input wire logic               core_clk,
	input wire logic               resetn,
	input wire logic [11:0]        paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [NUM_OUT-1:0] logic_out
);
	// ----------------------------------------------------------
	// Shadow of output 0 settings and its pulse width
	// ----------------------------------------------------------
	logic        ign_q;
	logic [23:0] cnt_q;
	logic        prev_q;
	logic [31:0] run_q;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ign_q  <= 1'b0;
			cnt_q  <= LGO_CFG_RST.dly_cnt;
			prev_q <= 1'b0;
			run_q  <= 32'h0;
		end else begin
			if (psel && penable && pwrite && paddr == LGO_OUT_BASE) begin
				ign_q <= pwdata[LGO_CFG_IGN];
				cnt_q <= pwdata[31:8];
			end
			prev_q <= logic_out[0];
			if (logic_out[0] != prev_q)
				run_q <= 32'h1;
			else if (!(&run_q))
				run_q <= run_q + 32'h1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	a_ready_access: assert property (s_setup ##1 s_access |-> pready)
		else $error("pready low in access phase");
	a_idle_quiet: assert property (!psel |-> !pready && !pslverr)
		else $error("pready or pslverr without select");
	a_err_misalign: assert property (
		(s_access and paddr[1:0] != 2'h0) |-> pslverr)
		else $error("misaligned access not refused");
	a_err_hole: assert property ((s_access and
		paddr[11:8] == 4'h0 && paddr[7:0] >= 8'h0c) |-> pslverr)
		else $error("unmapped access not refused");
	a_ctrl_ok: assert property (
		(s_access and paddr == LGO_CTRL_OFF) |-> !pslverr)
		else $error("control access refused");
	a_rdata_hold: assert property (!psel |=> $stable(prdata))
		else $error("read data moved while idle");
	a_out_reset: assert property (disable iff (1'b0) !resetn |-> logic_out == '0)
		else $error("output high during reset");
	a_out_release: assert property ($rose(resetn) |-> logic_out == '0 [*2])
		else $error("output high while reset lifts");
	a_ign_width: assert property (
		ign_q && logic_out[0] != prev_q |-> run_q >= 32'(cnt_q))
		else $error("output pulse shorter than delay");
endmodule // lgo_logic_out_checker

bind lgo_logic_out lgo_logic_out_checker #(.NUM_OUT(NUM_OUT)) u_chk (
	.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .logic_out(logic_out));

// [verif/lgo_logic_out_tb_top.sv]
// Purpose: Self-checking bench for the logic output block.
// Assumes: Bench drives rails, pins and output feedback directly.
// Notes:   Delays use a count of 5 to keep the run short.
`timescale 1ns/1ps
module lgo_logic_out_tb_top;
	import lgo_pkg::*;
	logic                                 core_clk;
	logic                                 resetn;
	logic [11:0]                          paddr;
	logic                                 psel;
	logic                                 penable;
	logic                                 pwrite;
	logic [31:0]                          pwdata;
	logic [31:0]                          prdata;
	logic                                 pready;
	logic                                 pslverr;
	logic [LGO_NGPI-1:0]                  gpi_pin;
	logic [LGO_N_LIVE-1:0][LGO_RAILS-1:0] rail_status;
	logic [LGO_NGPO-1:0]                  gpo_state;
	logic [11:0]                          logic_out;
	logic [31:0]                          rdat;
	logic                                 rerr;
	logic [31:0]                          lx;
	int                                   errors;
	int                                   compares;
	int                                   tt;
	int                                   src;
	int                                   i;
	logic [11:0] t_rm [9] = '{12'h003, 12'h001, 12'h003, 12'h000, 12'h000,
		12'h001, 12'h001, 12'h001, 12'h000};
	logic [7:0]  t_g  [9] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h00, 8'h00};
	logic [8:0]  t_o3 = 9'h008;
	logic [8:0]  t_e  = 9'h0c9;

	lgo_logic_out #(.NUM_OUT(12)) u_dut (
		.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gpi_pin(gpi_pin), .rail_status(rail_status),
		.gpo_state(gpo_state), .logic_out(logic_out));

	// ----------------------------------------------------------
	// Access and comparison tasks
	// ----------------------------------------------------------
	task check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task finish_test;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Waits on pready as long as it takes; only the watchdog ends a hang.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [11:0] oa(input logic [2:0] w);
		return LGO_OUT_BASE + {7'h0, w, 2'b00};
	endfunction

	task term(input logic [2:0] w, input logic [4:0] t, input logic [11:0] m,
		input logic [7:0] g, input logic [7:0] o);
		apb(1'b1, oa(w), {11'h0, t, 4'h0, m});
		apb(1'b1, oa(w + 3'h1), {16'h0, o, g});
	endtask

	task cfg(input logic [23:0] n, input logic [3:0] b);
		apb(1'b1, oa(LGO_W_CFG), {n, 4'h0, b});
	endtask

	task drv(input int t, input logic [11:0] m, input logic [7:0] g,
		input logic [7:0] o);
		logic [LGO_N_LIVE-1:0][LGO_RAILS-1:0] v;
		v = '0;
		v[t] = m;
		@(posedge core_clk);
		rail_status <= v;
		gpi_pin <= g;
		gpo_state <= o;
	endtask

	task wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task co(input logic e);
		check({31'h0, logic_out[0]}, {31'h0, e});
	endtask

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Whole sequence needs about 1100 cycles; this leaves ample margin.
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		finish_test;
	end

	// ----------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------
	initial begin
		errors = 0;
		compares = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		gpi_pin = 8'h00;
		rail_status = '0;
		gpo_state = 8'h00;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		wt(3);
		co(1'b0);
		apb(1'b0, oa(LGO_W_CFG), 32'h0);
		check(rdat, {24'(LGO_DLY_DEF_CYC), 8'h00});
		apb(1'b0, 12'h0fc, 32'h0);
		check({31'h0, rerr}, 32'h1);
		apb(1'b0, 12'h002, 32'h0);
		check({31'h0, rerr}, 32'h1);
		for (tt = 0; tt < 32; tt++) begin
			src = (tt < 17) ? tt : ((tt < 31) ? tt - 14 : 14);
			lx = (src == 14 || src == 15) ? 32'h4000 : 32'h0;
			term(LGO_W_T0A, tt[4:0], 12'h001, 8'h00, 8'h00);
			drv(src, 12'h001, 8'h00, 8'h00);
			wt(4);
			co(1'b1);
			if (src > 2) begin
				apb(1'b0, LGO_LATCH_OFF, 32'h0);
				check(rdat, (32'h1 << (src - 3)) | lx);
			end
			drv(src, 12'h000, 8'h00, 8'h00);
			wt(4);
			co(tt > 16);
			apb(1'b1, LGO_CTRL_OFF, 32'h1);
			wt(4);
			co(1'b0);
		end
		term(LGO_W_T0A, 5'h11, 12'h001, 8'h00, 8'h00);
		apb(1'b1, LGO_CTRL_OFF, 32'h210);
		drv(3, 12'h001, 8'h00, 8'h00);
		drv(3, 12'h000, 8'h00, 8'h00);
		wt(4);
		co(1'b1);
		drv(0, 12'h000, 8'h04, 8'h00);
		wt(6);
		co(1'b0);
		drv(0, 12'h000, 8'h00, 8'h00);
		apb(1'b1, LGO_CTRL_OFF, 32'h0);
		cfg(24'h0, 4'h0);
		term(LGO_W_T0A, 5'h00, 12'h003, 8'h01, 8'h00);
		term(LGO_W_T1A, 5'h00, 12'h000, 8'h00, 8'h80);
		for (i = 0; i < 9; i++) begin
			if (i == 5) begin
				cfg(24'h0, 4'h1);
				term(LGO_W_T0A, 5'h00, 12'h001, 8'h00, 8'h00);
				term(LGO_W_T1A, 5'h00, 12'h000, 8'h01, 8'h00);
			end
			drv(0, t_rm[i], t_g[i], {t_o3[i], 7'h00});
			wt(6);
			co(t_e[i]);
			apb(1'b0, LGO_STAT_OFF, 32'h0);
			check(rdat, {15'h0, t_e[i], 15'h0, t_e[i]});
		end
		cfg(24'h5, 4'h2);
		term(LGO_W_T0A, 5'h00, 12'h001, 8'h00, 8'h00);
		term(LGO_W_T1A, 5'h00, 12'h000, 8'h00, 8'h00);
		drv(0, 12'h001, 8'h00, 8'h00);
		wt(2);
		drv(0, 12'h000, 8'h00, 8'h00);
		wt(12);
		co(1'b0);
		drv(0, 12'h001, 8'h00, 8'h00);
		wt(3);
		drv(0, 12'h000, 8'h00, 8'h00);
		drv(0, 12'h001, 8'h00, 8'h00);
		wt(6);
		co(1'b0);
		wt(1);
		co(1'b1);
		drv(0, 12'h000, 8'h00, 8'h00);
		wt(1);
		co(1'b1);
		wt(1);
		co(1'b0);
		cfg(24'h0, 4'h2);
		drv(0, 12'h001, 8'h00, 8'h00);
		wt(1);
		co(1'b0);
		wt(1);
		co(1'b1);
		drv(0, 12'h000, 8'h00, 8'h00);
		cfg(24'h5, 4'he);
		wt(10);
		drv(0, 12'h001, 8'h00, 8'h00);
		drv(0, 12'h000, 8'h00, 8'h00);
		wt(5);
		co(1'b0);
		for (i = 0; i < 5; i++) begin
			wt(1);
			co(1'b1);
		end
		wt(30);
		co(1'b0);
		finish_test;
	end
endmodule // lgo_logic_out_tb_top
